//--- core/vrc_ctrl.sv
// host controller driving the random port of a dual-port video dram
module vrc_ctrl #(
  parameter int PWRUP_CYC = vrc_pkg::C_PWRUP, // power-up wait in cycles
  parameter int REF_CYC = vrc_pkg::C_REF_ROW, // cycles between row refreshes
  parameter bit USE_CBR = 1'b1 // init with column-first refresh
) (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic nrst, // async reset, active low
  input wire logic req_valid, // user request present
  input wire vrc_pkg::vrc_req_t req, // user request fields
  output logic req_ready, // request taken in the previous cycle
  output logic rsp_valid, // read data valid pulse
  output logic [7:0] rsp_data, // read data
  output logic init_done, // power-up sequence finished
  output logic [7:0] addr, // multiplexed address pins
  output vrc_pkg::vrc_strobe_t strb, // strobes and serial clock
  output logic [7:0] dq_out, // data/mask pin drive
  output logic dq_oe, // data/mask pin enable, high drives
  input wire logic [7:0] dq_in // data/mask pin level
);
  // state and counters
  vrc_pkg::vrc_state_t st_r, st_nxt;
  logic [15:0] cnt_r; // phase timer
  logic [15:0] ref_cnt_r; // refresh interval timer
  logic ref_due_r; // refresh owed
  logic [7:0] init_r; // init cycles done
  logic [7:0] ref_row_r; // next row-only refresh row
  vrc_pkg::vrc_req_t cur_r; // request in flight
  logic [7:0] dq_s1_r, dq_s2_r; // pin synchroniser
  logic in_ref_r; // refresh flag, only ever loaded with zero
  // derived decode
  wire cnt_done = (cnt_r == vrc_pkg::CNT_ZERO);
  wire ref_tick = (ref_cnt_r == vrc_pkg::CNT_ZERO);
  wire is_read = (cur_r.op == vrc_pkg::VRC_OP_READ);
  wire is_rmw = (cur_r.op == vrc_pkg::VRC_OP_RMW);
  wire is_write = (cur_r.op == vrc_pkg::VRC_OP_WRITE);
  wire take = (st_r == vrc_pkg::VRC_IDLE) && cnt_done && !ref_due_r && req_valid
    && init_done;
  wire page_take = (st_r == vrc_pkg::VRC_CP) && cnt_done && req_valid
    && !cur_r.page_last && (req.row == cur_r.row) && !ref_due_r;
  wire init_last = (init_r == vrc_pkg::INIT_LAST);

  // next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      vrc_pkg::VRC_PWR: begin
        if (cnt_done) st_nxt = USE_CBR ? vrc_pkg::VRC_RCSR : vrc_pkg::VRC_INIT;
      end
      vrc_pkg::VRC_INIT: begin
        if (cnt_done) st_nxt = vrc_pkg::VRC_PRE;
      end
      vrc_pkg::VRC_IDLE: begin
        // init cycles repeat until all eight are done
        if (cnt_done && !init_done) st_nxt = USE_CBR ? vrc_pkg::VRC_RCSR
          : vrc_pkg::VRC_INIT;
        else if (cnt_done && ref_due_r) st_nxt = vrc_pkg::VRC_RCSR;
        else if (take) st_nxt = vrc_pkg::VRC_RAS;
      end
      vrc_pkg::VRC_RAS: begin
        if (cnt_done) st_nxt = vrc_pkg::VRC_COL;
      end
      vrc_pkg::VRC_COL: st_nxt = vrc_pkg::VRC_CAS;
      vrc_pkg::VRC_CAS: begin
        if (cnt_done) st_nxt = is_rmw ? vrc_pkg::VRC_WEL : vrc_pkg::VRC_END;
      end
      vrc_pkg::VRC_WEL: begin
        if (cnt_done) st_nxt = vrc_pkg::VRC_END;
      end
      vrc_pkg::VRC_END: begin
        if (cnt_done) st_nxt = vrc_pkg::VRC_CP;
      end
      vrc_pkg::VRC_CP: begin
        if (page_take) st_nxt = vrc_pkg::VRC_COL;
        else if (cnt_done) st_nxt = vrc_pkg::VRC_PRE;
      end
      vrc_pkg::VRC_RCSR: begin
        if (cnt_done) st_nxt = vrc_pkg::VRC_RREF;
      end
      vrc_pkg::VRC_RREF: begin
        if (cnt_done) st_nxt = vrc_pkg::VRC_PRE;
      end
      vrc_pkg::VRC_PRE: begin
        if (cnt_done) st_nxt = vrc_pkg::VRC_IDLE;
      end
      default: st_nxt = vrc_pkg::VRC_IDLE;
    endcase
  end

  // phase timer load on each state entry
  logic [15:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_done ? cnt_r : cnt_r - vrc_pkg::CNT_ONE;
    if (st_nxt != st_r || page_take) begin
      case (st_nxt)
        vrc_pkg::VRC_INIT: cnt_nxt = 16'(vrc_pkg::C_RAS);
        vrc_pkg::VRC_RAS: cnt_nxt = 16'(vrc_pkg::C_RCD);
        vrc_pkg::VRC_CAS: cnt_nxt = is_rmw ? 16'(vrc_pkg::C_CWD)
          : 16'(vrc_pkg::C_CAS > vrc_pkg::C_OEA ? vrc_pkg::C_CAS : vrc_pkg::C_OEA);
        vrc_pkg::VRC_WEL: cnt_nxt = 16'(vrc_pkg::C_WP);
        vrc_pkg::VRC_END: cnt_nxt = 16'(vrc_pkg::C_RAS);
        vrc_pkg::VRC_CP: cnt_nxt = 16'(vrc_pkg::C_CP);
        vrc_pkg::VRC_RCSR: cnt_nxt = 16'(vrc_pkg::C_CSR);
        vrc_pkg::VRC_RREF: cnt_nxt = 16'(vrc_pkg::C_RAS > vrc_pkg::C_CHR
          ? vrc_pkg::C_RAS : vrc_pkg::C_CHR);
        vrc_pkg::VRC_PRE: cnt_nxt = 16'(vrc_pkg::C_RP);
        default: cnt_nxt = vrc_pkg::CNT_ZERO;
      endcase
    end
  end

  // state register and timers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= vrc_pkg::VRC_PWR;
      cnt_r <= 16'(PWRUP_CYC); // power-up wait starts at release
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // refresh interval and debt flag; a tick beats the clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_cnt_r <= 16'(REF_CYC);
      ref_due_r <= 1'b0;
    end else begin
      ref_cnt_r <= ref_tick ? 16'(REF_CYC) : ref_cnt_r - vrc_pkg::CNT_ONE;
      if (ref_tick && init_done) ref_due_r <= 1'b1;
      else if (st_r == vrc_pkg::VRC_RREF) ref_due_r <= 1'b0;
    end
  end

  // init cycle counter and done flag
  wire init_step = (st_r == vrc_pkg::VRC_PRE) && cnt_done && !init_done;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      init_r <= vrc_pkg::BYTE_ZERO;
      init_done <= 1'b0;
    end else if (init_step) begin
      init_r <= init_r + vrc_pkg::BYTE_ONE;
      if (init_last) init_done <= 1'b1;
    end
  end

  // request capture
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur_r <= '0;
      in_ref_r <= 1'b0;
    end else if (take || page_take) begin
      cur_r <= req;
      in_ref_r <= 1'b0;
    end
  end

  // row-only refresh row counter kept for bookkeeping of refresh spread
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) ref_row_r <= vrc_pkg::BYTE_ZERO;
    else if (st_r == vrc_pkg::VRC_INIT && st_nxt == vrc_pkg::VRC_PRE)
      ref_row_r <= ref_row_r + vrc_pkg::BYTE_ONE;
  end

  // data pin synchroniser
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dq_s1_r <= vrc_pkg::BYTE_ZERO;
      dq_s2_r <= vrc_pkg::BYTE_ZERO;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // pin levels for the next cycle
  wire ras_low = (st_nxt == vrc_pkg::VRC_RAS) || (st_nxt == vrc_pkg::VRC_COL)
    || (st_nxt == vrc_pkg::VRC_CAS) || (st_nxt == vrc_pkg::VRC_WEL)
    || (st_nxt == vrc_pkg::VRC_END) || (st_nxt == vrc_pkg::VRC_CP)
    || (st_nxt == vrc_pkg::VRC_RREF) || (st_nxt == vrc_pkg::VRC_INIT);
  wire cas_low = (st_nxt == vrc_pkg::VRC_CAS) || (st_nxt == vrc_pkg::VRC_WEL)
    || (st_nxt == vrc_pkg::VRC_END) || (st_nxt == vrc_pkg::VRC_RCSR)
    || (st_nxt == vrc_pkg::VRC_RREF);
  wire nx_new = take || page_take;
  vrc_pkg::vrc_req_t nx_req;
  assign nx_req = nx_new ? req : cur_r;
  wire nx_wr = nx_req.op != vrc_pkg::VRC_OP_READ;
  // write/mask line: low at row fall selects masking, low before column early write
  wire we_low = ((st_nxt == vrc_pkg::VRC_RAS) && nx_req.use_mask && nx_wr)
    || ((st_nxt == vrc_pkg::VRC_COL || st_nxt == vrc_pkg::VRC_CAS
      || st_nxt == vrc_pkg::VRC_END) && nx_req.op == vrc_pkg::VRC_OP_WRITE)
    || ((st_nxt == vrc_pkg::VRC_WEL || st_nxt == vrc_pkg::VRC_END)
      && nx_req.op == vrc_pkg::VRC_OP_RMW);
  // output enable low only for reads and the read half of rmw
  wire oe_low = ((st_nxt == vrc_pkg::VRC_CAS) && nx_req.op != vrc_pkg::VRC_OP_WRITE)
    || ((st_nxt == vrc_pkg::VRC_END) && nx_req.op == vrc_pkg::VRC_OP_READ);
  // data drive: mask at row fall, write data for writes
  wire drv_mask = (st_nxt == vrc_pkg::VRC_RAS) && nx_req.use_mask && nx_wr;
  wire drv_data = ((st_nxt == vrc_pkg::VRC_COL || st_nxt == vrc_pkg::VRC_CAS
      || st_nxt == vrc_pkg::VRC_END) && nx_req.op == vrc_pkg::VRC_OP_WRITE)
    || ((st_nxt == vrc_pkg::VRC_WEL || (st_nxt == vrc_pkg::VRC_END && is_rmw))
      && nx_req.op == vrc_pkg::VRC_OP_RMW);
  wire col_phase = (st_nxt == vrc_pkg::VRC_COL) || (st_nxt == vrc_pkg::VRC_CAS)
    || (st_nxt == vrc_pkg::VRC_WEL) || (st_nxt == vrc_pkg::VRC_END);
  wire [7:0] addr_nxt = col_phase ? nx_req.col
    : (st_nxt == vrc_pkg::VRC_INIT ? init_r : nx_req.row);
  // read data taken at the end of the output phase, before any write drive
  wire cap_rd = (st_r == vrc_pkg::VRC_CAS) && cnt_done && !is_write;
  // one serial clock pulse per init precharge
  wire sclk_nxt = (st_r == vrc_pkg::VRC_PRE) && (cnt_r == vrc_pkg::CNT_ONE)
    && !init_done;

  // registered pin outputs; strobes high during reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strb <= '{ras_n: 1'b1, cas_n: 1'b1, wmwe_n: 1'b1, toe_n: 1'b1, sclk: 1'b0};
      addr <= vrc_pkg::BYTE_ZERO;
      dq_out <= vrc_pkg::BYTE_ZERO;
      dq_oe <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= vrc_pkg::BYTE_ZERO;
    end else begin
      strb.ras_n <= !ras_low;
      strb.cas_n <= !cas_low;
      strb.wmwe_n <= !we_low;
      strb.toe_n <= !oe_low;
      strb.sclk <= sclk_nxt;
      addr <= addr_nxt;
      dq_out <= drv_mask ? nx_req.mask : nx_req.wdata;
      dq_oe <= drv_mask || drv_data;
      req_ready <= nx_new;
      rsp_valid <= cap_rd;
      if (cap_rd) rsp_data <= dq_s2_r;
    end
  end
endmodule : vrc_ctrl

//--- core/vrc_pkg.sv
// package for the video dram random-port host controller
package vrc_pkg;
  // clock rate and timing figures (ns unless marked)
  localparam int CLK_NS = 40;
  localparam int T_RP_NS = 70;
  localparam int T_RAS_NS = 100;
  localparam int T_RCD_NS = 25;
  localparam int T_CAS_NS = 25;
  localparam int T_CP_NS = 15;
  localparam int T_CSR_NS = 10;
  localparam int T_CHR_NS = 20;
  localparam int T_OEA_NS = 25;
  localparam int T_CWD_NS = 50;
  localparam int T_WP_NS = 20;
  localparam int T_REF_MS = 4;
  localparam int T_PWRUP_US = 200;
  localparam int N_ROWS = 256;
  localparam int N_INIT = 8;
  // least times round up to whole cycles; output enable access takes one cycle more
  localparam int C_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RAS = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RCD = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CAS = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CP = (T_CP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CSR = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_CHR = (T_CHR_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_OEA = (T_OEA_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int C_CWD = (T_CWD_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_WP = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  // longest time rounds down: refresh period over rows, per-row interval
  localparam int C_REF_ROW = (T_REF_MS * 1000000 / CLK_NS) / N_ROWS;
  localparam int C_PWRUP = T_PWRUP_US * 1000 / CLK_NS;
  // widths
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int CW = 16;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [7:0] INIT_LAST = 8'h07;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  // access kinds requested by the user side
  typedef enum logic [1:0] {
    VRC_OP_READ = 2'h0,
    VRC_OP_WRITE = 2'h1,
    VRC_OP_RMW = 2'h2
  } vrc_op_t;

  // one user request
  typedef struct packed {
    vrc_op_t op;
    logic [7:0] row;
    logic [7:0] col;
    logic [7:0] wdata;
    logic [7:0] mask;
    logic use_mask;
    logic page_last;
  } vrc_req_t;

  // strobe bundle driven to the memory
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic wmwe_n;
    logic toe_n;
    logic sclk;
  } vrc_strobe_t;

  // controller states, one bit apart from idle through row, column, cas and wel to end
  typedef enum logic [3:0] {
    VRC_PWR = 4'h0,
    VRC_IDLE = 4'h1,
    VRC_RAS = 4'h3,
    VRC_COL = 4'h2,
    VRC_CAS = 4'h6,
    VRC_WEL = 4'h7,
    VRC_END = 4'h5,
    VRC_PRE = 4'h4,
    VRC_CP = 4'hC,
    VRC_RCSR = 4'hD,
    VRC_RREF = 4'hF,
    VRC_INIT = 4'hE
  } vrc_state_t;
endpackage : vrc_pkg

//--- verification/vrc_ctrl_monitor.sv
// checker for the random-port host controller
module vrc_ctrl_monitor #(
  parameter int PWRUP_CYC = vrc_pkg::C_PWRUP, // power-up wait
  parameter int REF_CYC = vrc_pkg::C_REF_ROW, // refresh spacing
  parameter bit USE_CBR = 1'b1 // counter refresh init
) (
  input wire logic sys_clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic req_valid, // request present
  input wire vrc_pkg::vrc_req_t req, // request fields
  input wire logic req_ready, // request taken
  input wire logic rsp_valid, // read data valid
  input wire logic [7:0] rsp_data, // read data
  input wire logic init_done, // init finished
  input wire logic [7:0] addr, // address pins
  input wire vrc_pkg::vrc_strobe_t strb, // strobes
  input wire logic [7:0] dq_out, // data drive
  input wire logic dq_oe, // data enable
  input wire logic [7:0] dq_in // data level
);
  timeunit 1ns;
  timeprecision 100ps;
  int pw_cnt_r; // cycles since reset
  int gap_r; // cycles since counter refresh
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // counts power-up wait and refresh spacing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pw_cnt_r <= 0;
      gap_r <= 0;
    end else begin
      pw_cnt_r <= (pw_cnt_r < PWRUP_CYC) ? pw_cnt_r + 1 : pw_cnt_r;
      gap_r <= (!init_done || ($fell(strb.ras_n) && !strb.cas_n)) ? 0 : gap_r + 1;
    end
  end
  row_addr_a: assert property (req_ready && $fell(strb.ras_n) |-> addr == req.row && strb.cas_n)
    else $error("row address or column strobe wrong at row fall");
  col_addr_a: assert property ($fell(strb.cas_n) && !strb.ras_n |-> $stable(addr) && !$past(strb.ras_n))
    else $error("column address not settled at column fall");
  precharge_a: assert property ($rose(strb.ras_n) |-> strb.ras_n [*2])
    else $error("row precharge too short");
  ras_width_a: assert property ($fell(strb.ras_n) |-> !strb.ras_n [*3])
    else $error("row strobe pulse too short");
  read_we_a: assert property (req_ready && req.op == vrc_pkg::VRC_OP_READ |=> strb.wmwe_n [*3])
    else $error("write enable low during read");
  mask_sel_a: assert property (req_ready && $fell(strb.ras_n)
      |-> strb.wmwe_n == !(req.use_mask && req.op != vrc_pkg::VRC_OP_READ))
    else $error("mask select wrong at row fall");
  mask_data_a: assert property (req_ready && $fell(strb.ras_n) && !strb.wmwe_n
      |-> dq_oe && dq_out == req.mask)
    else $error("mask byte not driven at row fall");
  no_clash_a: assert property (!strb.toe_n && !strb.cas_n |-> !dq_oe)
    else $error("data driven while device outputs");
  oe_width_a: assert property ($fell(strb.toe_n) |-> !strb.toe_n [*2])
    else $error("output enable low too short");
  wdata_a: assert property (!strb.ras_n && !strb.cas_n && !strb.wmwe_n |-> dq_oe)
    else $error("write data not driven");
  page_ras_a: assert property (req_ready |-> !strb.ras_n)
    else $error("row strobe high when request taken");
  pwr_hold_a: assert property (pw_cnt_r < PWRUP_CYC |-> strb.ras_n && strb.toe_n && !req_ready)
    else $error("strobes moved during power-up wait");
  init_cbr_a: assert property (USE_CBR && !init_done && $fell(strb.ras_n) |-> !strb.cas_n)
    else $error("init cycle not counter refresh");
  refresh_gap_a: assert property (gap_r <= REF_CYC + 40)
    else $error("refresh overdue");
  c_read: cover property (rsp_valid);
  c_mask: cover property (req_ready && $fell(strb.ras_n) && !strb.wmwe_n);
  c_page: cover property (req_ready && !$fell(strb.ras_n));
  c_cbr: cover property (init_done && $fell(strb.ras_n) && !strb.cas_n);
endmodule : vrc_ctrl_monitor

//--- verification/vrc_dram_model.sv
// behavioural model of the video dram random port
module vrc_dram_model (
  input wire logic [7:0] addr, // address pins
  input wire vrc_pkg::vrc_strobe_t strb, // strobes
  input wire logic [7:0] dq, // resolved data pins
  output logic dev_oe, // device drives data
  output logic [7:0] dev_q // device data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535]; // stored bytes
  logic [7:0] row_r = 8'h00; // latched row
  logic [7:0] col_r = 8'h00; // latched column
  logic [7:0] wmask_r = 8'hFF; // write mask latch
  bit cbr_r = 1'b0; // counter refresh cycle
  bit rd_r = 1'b0; // read data allowed
  int ref_cnt = 0; // internal refresh counter
  initial foreach (mem[i]) mem[i] = 8'h00;
  // row fall: refresh select, row and mask latch
  always @(negedge strb.ras_n) begin
    #1;
    cbr_r = !strb.cas_n;
    if (cbr_r) ref_cnt = ref_cnt + 1;
    row_r = addr;
    wmask_r = strb.wmwe_n ? 8'hFF : dq;
  end
  // column fall: column latch, early write
  always @(negedge strb.cas_n) begin
    #1;
    if (!strb.ras_n && !cbr_r) begin
      col_r = addr;
      rd_r = strb.wmwe_n;
      if (!strb.wmwe_n) wr_byte();
    end
  end
  // late write enable fall: read-modify-write
  always @(negedge strb.wmwe_n) begin
    #1;
    if (!strb.ras_n && !strb.cas_n && !cbr_r) wr_byte();
  end
  // cycle end turns outputs off
  always @(posedge strb.cas_n) rd_r = 1'b0;
  assign dev_oe = rd_r && !strb.cas_n && !strb.toe_n && !strb.ras_n;
  assign dev_q = mem[{row_r, col_r}];
  // masked merge of new data
  task automatic wr_byte();
    mem[{row_r, col_r}] = (mem[{row_r, col_r}] & ~wmask_r) | (dq & wmask_r);
  endtask : wr_byte
endmodule : vrc_dram_model

//--- verification/tb_top.sv
// testbench for the random-port host controller
bind vrc_ctrl vrc_ctrl_monitor #(.PWRUP_CYC(PWRUP_CYC), .REF_CYC(REF_CYC), .USE_CBR(USE_CBR))
  u_mon (.sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done),
  .addr(addr), .strb(strb), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = 20; // shortened power-up wait
  localparam int RC = 50; // shortened refresh spacing
  logic sys_clk = 1'b0; // clock
  logic nrst = 1'b0; // reset, active low
  logic req_valid = 1'b0; // request present
  vrc_pkg::vrc_req_t req = '0; // request fields
  logic req_ready, rsp_valid, init_done, dq_oe, dev_oe; // handshakes and enables
  logic [7:0] rsp_data, addr, dq_out, dev_q, dq_w; // data paths
  logic [7:0] last_w = 8'h00; // last driven pin level
  vrc_pkg::vrc_strobe_t strb; // strobes
  logic [7:0] ref_mem [int]; // reference bytes
  logic [7:0] expq [$]; // expected read bytes
  int n_errors = 0;
  int total_checks = 0;
  int n_ras = 0; // row falls during init
  int n_sc = 0; // serial clocks during init
  initial forever #20 sys_clk = ~sys_clk;
  // released pins show the inverse of the last level
  assign dq_w = dq_oe ? dq_out : (dev_oe ? dev_q : ~last_w);
  always @(posedge sys_clk) if (dq_oe || dev_oe) last_w <= dq_w;
  always @(negedge strb.ras_n) if (nrst && !init_done) n_ras = n_ras + 1;
  always @(posedge strb.sclk) if (nrst && !init_done) n_sc = n_sc + 1;
  vrc_ctrl #(.PWRUP_CYC(PW), .REF_CYC(RC), .USE_CBR(1'b1)) DUT (.sys_clk(sys_clk),
    .nrst(nrst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done), .addr(addr),
    .strb(strb), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_w));
  vrc_dram_model u_dram (.addr(addr), .strb(strb), .dq(dq_w), .dev_oe(dev_oe), .dev_q(dev_q));
  // compare seen with expected
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // one request, reference updated, held until taken
  task automatic do_req(input vrc_pkg::vrc_op_t op, input logic [7:0] row, input logic [7:0] col,
      input logic [7:0] wd, input logic [7:0] mk, input logic um, input logic pl);
    logic [7:0] old, m;
    int n;
    old = ref_mem.exists({row, col}) ? ref_mem[{row, col}] : 8'h00;
    m = (um && op != vrc_pkg::VRC_OP_READ) ? mk : 8'hFF;
    if (op != vrc_pkg::VRC_OP_WRITE) expq.push_back(old);
    if (op != vrc_pkg::VRC_OP_READ) ref_mem[{row, col}] = (old & ~m) | (wd & m);
    req <= '{op, row, col, wd, mk, um, pl};
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n = n + 1;
    end while (req_ready !== 1'b1 && n < 500);
    if (n >= 500) check(8'h00, 8'h01);
    @(negedge sys_clk);
  endtask : do_req
  // read results against the reference queue
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (expq.size() == 0) check(rsp_data, 8'hXX);
      else check(rsp_data, expq.pop_front());
    end
  end
  initial begin
    #(40ns * 20000);
    n_errors = n_errors + 1;
    final_report();
  end
  initial begin
    int n;
    void'($urandom(68));
    repeat (4) @(negedge sys_clk);
    check(8'(strb[4:1]), 8'h0F);
    nrst = 1'b1;
    n = 0;
    while (init_done !== 1'b1 && n < 5000) begin
      @(negedge sys_clk);
      n = n + 1;
    end
    check(8'(n_ras), 8'h08);
    check(8'(n_sc), 8'h08);
    check(8'(u_dram.ref_cnt), 8'h08);
    $display("test init done");
    for (int i = 0; i < 30; i++)
      do_req(vrc_pkg::vrc_op_t'(i % 3), 8'($urandom_range(0, 1)), 8'($urandom_range(0, 3)),
        8'($urandom), 8'($urandom), 1'($urandom), 1'b1);
    req_valid <= 1'b0;
    repeat (40) @(negedge sys_clk);
    check(8'(expq.size()), 8'h00);
    $display("test random done");
    for (int i = 0; i < 6; i++)
      do_req(vrc_pkg::vrc_op_t'(i % 3), 8'h5A, 8'(i / 3), 8'($urandom), 8'hFF, 1'b0, 1'(i == 5));
    req_valid <= 1'b0;
    repeat (40) @(negedge sys_clk);
    check(8'(expq.size()), 8'h00);
    $display("test page done");
    n = u_dram.ref_cnt;
    repeat (3 * RC) @(negedge sys_clk);
    check(8'(u_dram.ref_cnt - n >= 2), 8'h01);
    $display("test refresh done");
    final_report();
  end
endmodule : tb_top
